//--- rtl/fse_pkg.sv
package fse_pkg;
    localparam logic [7:0] FSE_OFF_CTRL = 8'h00;
    localparam logic [7:0] FSE_OFF_STATUS = 8'h04;
    localparam logic [7:0] FSE_OFF_CMD = 8'h08;
    localparam logic [7:0] FSE_OFF_OPERAND = 8'h0C;
    localparam logic [7:0] FSE_OFF_AC0 = 8'h10;
    localparam logic [7:0] FSE_OFF_PC = 8'h20;
    localparam logic [7:0] FSE_OFF_SP = 8'h24;
    localparam logic [7:0] FSE_OFF_FP = 8'h28;
    localparam logic [7:0] FSE_OFF_LIMIT = 8'h2C;
    localparam logic [7:0] FSE_OFF_CARRY = 8'h30;
    localparam int FSE_CTRL_START = 0;
    localparam int FSE_CTRL_INT_EN = 1;
    localparam int FSE_CTRL_MAP_EN = 2;
    localparam int FSE_CMD_ACS = 4;
    localparam int FSE_CMD_ACD = 6;
    localparam int FSE_CMD_N = 8;
    localparam int FSE_CMD_CARRY = 10;
    localparam int FSE_CMD_SHIFT = 12;
    localparam int FSE_CMD_NOLOAD = 14;
    localparam int FSE_CMD_SKIP = 16;
    localparam logic [15:0] FSE_RST_WORD = 16'h0000;
    localparam logic [15:0] FSE_RST_LIMIT = 16'hFFFF;
    localparam logic [15:0] FSE_SYSCALL_VEC = 16'h0002;
    localparam logic [2:0] FSE_PUSH_LAST = 3'h4;
    localparam logic [1:0] FSE_RESP_OKAY = 2'b00;
    localparam logic [1:0] FSE_RESP_SLVERR = 2'b10;

    typedef enum logic [3:0] {
        OP_FRAME_SAVE = 4'h0,
        OP_MINUS_IMMEDIATE = 4'h1,
        OP_SKIP_GREATER_EQUAL = 4'h2,
        OP_SKIP_GREATER = 4'h3,
        OP_CPU_FLAG_TEST = 4'h4,
        OP_IO_FLAG_TEST = 4'h5,
        OP_SKIP_BIT_SET = 4'h6,
        OP_SKIP_BIT_CLEAR = 4'h7,
        OP_WORD_STORE = 4'h8,
        OP_BYTE_STORE = 4'h9,
        OP_UNSIGNED_SUB = 4'hA,
        OP_SYSTEM_CALL = 4'hB
    } fse_op_t;

    typedef enum logic [1:0] {
        PK_FRAME = 2'b00,
        PK_SYSCALL = 2'b01,
        PK_FAULT = 2'b10
    } fse_push_t;
endpackage : fse_pkg

//--- rtl/fse_alu_if.sv
`timescale 1ns/100ps
interface fse_alu_if;
    logic [15:0] acs;
    logic [15:0] acd;
    logic carry_in;
    logic [1:0] carry_sel;
    logic [1:0] shift_sel;
    logic [2:0] skip_sel;
    logic [15:0] result;
    logic carry_out;
    logic skip;
    logic ge;
    logic gt;
    modport alu (input acs, acd, carry_in, carry_sel, shift_sel, skip_sel,
                 output result, carry_out, skip, ge, gt);
    modport core (output acs, acd, carry_in, carry_sel, shift_sel, skip_sel,
                  input result, carry_out, skip, ge, gt);
endinterface : fse_alu_if

//--- rtl/fse_alu.sv
`timescale 1ns/100ps
module fse_alu (
    fse_alu_if.alu a
);
    logic cin;
    logic [16:0] sum;
    logic [16:0] val;
    logic [16:0] sh;
    always_comb begin
        unique case (a.carry_sel)
            2'b00: cin = a.carry_in;
            2'b01: cin = 1'b0;
            2'b10: cin = 1'b1;
            2'b11: cin = ~a.carry_in;
        endcase
        sum = {1'b0, a.acd} + {1'b0, ~a.acs} + 17'h00001;
        val = {cin ^ sum[16], sum[15:0]};
        unique case (a.shift_sel)
            2'b00: sh = val;
            2'b01: sh = {val[15:0], val[16]};
            2'b10: sh = {val[0], val[16:1]};
            2'b11: sh = {val[16], val[7:0], val[15:8]};
        endcase
        a.result = sh[15:0];
        a.carry_out = sh[16];
        unique case (a.skip_sel)
            3'b000: a.skip = 1'b0;
            3'b001: a.skip = 1'b1;
            3'b010: a.skip = ~sh[16];
            3'b011: a.skip = sh[16];
            3'b100: a.skip = (sh[15:0] == 16'h0000);
            3'b101: a.skip = (sh[15:0] != 16'h0000);
            3'b110: a.skip = ~sh[16] | (sh[15:0] == 16'h0000);
            3'b111: a.skip = sh[16] & (sh[15:0] != 16'h0000);
        endcase
        a.ge = ($signed(a.acs) >= $signed(a.acd));
        a.gt = ($signed(a.acs) > $signed(a.acd));
    end
endmodule : fse_alu

//--- rtl/fse_sync.sv
`timescale 1ns/100ps
module fse_sync #(
    parameter int W = 1
) (
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic [W-1:0] din,
    output logic [W-1:0] dout
);
    logic [W-1:0] meta_reg;
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            meta_reg <= '0;
            dout <= '0;
        end else begin
            meta_reg <= din;
            dout <= meta_reg;
        end
    end
endmodule : fse_sync

//--- rtl/fse_core.sv
// Local design decisions: the register offsets and the AXI4-Lite slave port.
`timescale 1ns/100ps
// Functional notes
// - frame save pushes ac0, ac1, ac2; pointer increments before every write
// - fourth frame word is zero top bit plus frame pointer low fifteen bits
// - fifth frame word is carry on top plus low fifteen bits of ac3
// - after five pushes, pointer above limit pushes fault block over return block
// - without overflow, stack pointer goes to frame pointer and ac3
// - without overflow, unsigned immediate frame size is added to stack pointer
// - minus immediate subtracts field plus one, writes back, carry untouched
// - signed compare skips when source is at least destination
// - signed compare skips only when source exceeds destination
// - cpu flag test: interrupts on, off, power one, power zero
// - device flag test: busy one, busy zero, done one, done zero
// - bit pointer: source base, destination offset and bit; skip when set
// - same pointer, skip when the bit is zero; accumulators unchanged
// - same accumulator for both operands uses base address zero
// - word store writes accumulator to effective address, accumulator kept
// - byte store writes low byte of destination at source byte pointer
// - unsigned subtract adds source complement plus one, carry flips on carry out
// - shifted value loads carry and destination unless no-load; skip test
// - system call turns translation off, pushes return block, jumps via 2
// - interrupts held off until the instruction after the system call
// - system call with ac0 twice pushes nothing and keeps ac0
module fse_core
    import fse_pkg::*;
(
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic [7:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [7:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    output logic mem_req,
    output logic mem_we,
    output logic [15:0] mem_addr,
    output logic [15:0] mem_wdata,
    output logic [1:0] mem_be,
    input wire logic [15:0] mem_rdata,
    input wire logic mem_ack,
    output logic [5:0] io_device,
    input wire logic io_busy,
    input wire logic io_done,
    input wire logic power_flag,
    output logic map_enable,
    output logic int_hold,
    output logic done_pulse
);
    typedef enum logic [2:0] {
        ST_IDLE = 3'b000,
        ST_PUSH = 3'b001,
        ST_WAIT_WR = 3'b010,
        ST_CHECK = 3'b011,
        ST_WAIT_RD = 3'b100,
        ST_FINISH = 3'b101
    } fse_state_t;

    fse_state_t state_reg;
    fse_push_t kind_reg;
    logic [15:0] ac_reg [4];
    logic [15:0] pc_reg, sp_reg, fp_reg, limit_reg, saved_sp_reg, operand_reg;
    logic [18:0] cmd_reg;
    logic carry_reg, int_en_reg, skip_reg, fault_reg, jump_reg;
    logic [2:0] cnt_reg;
    logic [2:0] flags_sync;
    logic wr_go, start;
    logic [15:0] wval;
    fse_op_t op;
    logic [1:0] acs, acd, tsel;
    logic [15:0] base, push_word;
    fse_alu_if alu_bus ();

    fse_alu u_alu (.a(alu_bus));
    fse_sync #(.W(3)) u_sync (
        .aclk(aclk),
        .aresetn(aresetn),
        .din({io_busy, io_done, power_flag}),
        .dout(flags_sync)
    );

    function automatic logic flag_test(input logic [1:0] t, input logic f1, input logic f2);
        unique case (t)
            2'b00: flag_test = f1;
            2'b01: flag_test = ~f1;
            2'b10: flag_test = f2;
            2'b11: flag_test = ~f2;
        endcase
    endfunction : flag_test

    function automatic logic [15:0] lanes(input logic [15:0] old, input logic [31:0] d,
                                          input logic [3:0] s);
        lanes = {s[1] ? d[15:8] : old[15:8], s[0] ? d[7:0] : old[7:0]};
    endfunction : lanes

    assign op = fse_op_t'(cmd_reg[3:0]);
    assign acs = cmd_reg[FSE_CMD_ACS +: 2];
    assign acd = cmd_reg[FSE_CMD_ACD +: 2];
    assign tsel = cmd_reg[FSE_CMD_N +: 2];
    assign io_device = operand_reg[5:0];
    assign base = (acs == acd) ? FSE_RST_WORD : ac_reg[acs];
    assign alu_bus.acs = ac_reg[acs];
    assign alu_bus.acd = ac_reg[acd];
    assign alu_bus.carry_in = carry_reg;
    assign alu_bus.carry_sel = cmd_reg[FSE_CMD_CARRY +: 2];
    assign alu_bus.shift_sel = cmd_reg[FSE_CMD_SHIFT +: 2];
    assign alu_bus.skip_sel = cmd_reg[FSE_CMD_SKIP +: 3];

    always_comb begin
        unique case (cnt_reg)
            3'h0: push_word = ac_reg[0];
            3'h1: push_word = ac_reg[1];
            3'h2: push_word = ac_reg[2];
            3'h3: push_word = (kind_reg == PK_FRAME) ? {1'b0, fp_reg[14:0]} : ac_reg[3];
            default: begin
                if (kind_reg == PK_FRAME) begin
                    push_word = {carry_reg, ac_reg[3][14:0]};
                end else begin
                    push_word = {carry_reg, pc_reg[14:0] + 15'h0001};
                end
            end
        endcase
    end

    // register bus: write address and data are taken together
    assign wr_go = s_axi_awvalid & s_axi_wvalid & ~s_axi_bvalid;
    assign s_axi_awready = wr_go;
    assign s_axi_wready = wr_go;
    assign s_axi_arready = ~s_axi_rvalid;
    assign wval = s_axi_wdata[15:0];
    assign start = wr_go && s_axi_awaddr == FSE_OFF_CTRL && s_axi_wstrb[0]
                   && s_axi_wdata[FSE_CTRL_START] && state_reg == ST_IDLE;

    function automatic logic mapped(input logic [7:0] a);
        mapped = (a[1:0] == 2'b00) && (a <= FSE_OFF_CARRY);
    endfunction : mapped

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s_axi_bvalid <= 1'b0;
            s_axi_bresp <= FSE_RESP_OKAY;
        end else if (wr_go) begin
            s_axi_bvalid <= 1'b1;
            s_axi_bresp <= mapped(s_axi_awaddr) ? FSE_RESP_OKAY : FSE_RESP_SLVERR;
        end else if (s_axi_bready) begin
            s_axi_bvalid <= 1'b0;
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s_axi_rvalid <= 1'b0;
            s_axi_rdata <= 32'h00000000;
            s_axi_rresp <= FSE_RESP_OKAY;
        end else if (s_axi_arvalid && !s_axi_rvalid) begin
            s_axi_rvalid <= 1'b1;
            s_axi_rresp <= mapped(s_axi_araddr) ? FSE_RESP_OKAY : FSE_RESP_SLVERR;
            unique case (s_axi_araddr)
                FSE_OFF_CTRL: s_axi_rdata <= {29'h0, map_enable, int_en_reg, 1'b0};
                FSE_OFF_STATUS: s_axi_rdata <= {27'h0, map_enable, int_hold, fault_reg,
                                                skip_reg, state_reg != ST_IDLE};
                FSE_OFF_CMD: s_axi_rdata <= {13'h0, cmd_reg};
                FSE_OFF_OPERAND: s_axi_rdata <= {16'h0, operand_reg};
                8'h10, 8'h14, 8'h18, 8'h1C: s_axi_rdata <= {16'h0, ac_reg[s_axi_araddr[3:2]]};
                FSE_OFF_PC: s_axi_rdata <= {16'h0, pc_reg};
                FSE_OFF_SP: s_axi_rdata <= {16'h0, sp_reg};
                FSE_OFF_FP: s_axi_rdata <= {16'h0, fp_reg};
                FSE_OFF_LIMIT: s_axi_rdata <= {16'h0, limit_reg};
                FSE_OFF_CARRY: s_axi_rdata <= {31'h0, carry_reg};
                default: s_axi_rdata <= 32'h00000000;
            endcase
        end else if (s_axi_rready) begin
            s_axi_rvalid <= 1'b0;
        end
    end

    // execution sequencer and the state it owns
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            state_reg <= ST_IDLE;
            kind_reg <= PK_FRAME;
            for (int i = 0; i < 4; i++) begin
                ac_reg[i] <= FSE_RST_WORD;
            end
            pc_reg <= FSE_RST_WORD;
            sp_reg <= FSE_RST_WORD;
            fp_reg <= FSE_RST_WORD;
            limit_reg <= FSE_RST_LIMIT;
            saved_sp_reg <= FSE_RST_WORD;
            operand_reg <= FSE_RST_WORD;
            cmd_reg <= '0;
            carry_reg <= 1'b0;
            int_en_reg <= 1'b0;
            map_enable <= 1'b0;
            int_hold <= 1'b0;
            skip_reg <= 1'b0;
            fault_reg <= 1'b0;
            jump_reg <= 1'b0;
            cnt_reg <= 3'h0;
            mem_req <= 1'b0;
            mem_we <= 1'b0;
            mem_addr <= FSE_RST_WORD;
            mem_wdata <= FSE_RST_WORD;
            mem_be <= 2'b00;
            done_pulse <= 1'b0;
        end else begin
            done_pulse <= 1'b0;
            if (wr_go && state_reg == ST_IDLE) begin
                unique case (s_axi_awaddr)
                    FSE_OFF_CTRL: begin
                        if (s_axi_wstrb[0]) begin
                            int_en_reg <= s_axi_wdata[FSE_CTRL_INT_EN];
                            map_enable <= s_axi_wdata[FSE_CTRL_MAP_EN];
                        end
                    end
                    FSE_OFF_CMD: cmd_reg <= {s_axi_wstrb[2] ? s_axi_wdata[18:16] : cmd_reg[18:16],
                                             lanes(cmd_reg[15:0], s_axi_wdata, s_axi_wstrb)};
                    FSE_OFF_OPERAND: operand_reg <= lanes(operand_reg, s_axi_wdata, s_axi_wstrb);
                    8'h10, 8'h14, 8'h18, 8'h1C: ac_reg[s_axi_awaddr[3:2]] <=
                        lanes(ac_reg[s_axi_awaddr[3:2]], s_axi_wdata, s_axi_wstrb);
                    FSE_OFF_PC: pc_reg <= lanes(pc_reg, s_axi_wdata, s_axi_wstrb);
                    FSE_OFF_SP: sp_reg <= lanes(sp_reg, s_axi_wdata, s_axi_wstrb);
                    FSE_OFF_FP: fp_reg <= lanes(fp_reg, s_axi_wdata, s_axi_wstrb);
                    FSE_OFF_LIMIT: limit_reg <= lanes(limit_reg, s_axi_wdata, s_axi_wstrb);
                    FSE_OFF_CARRY: if (s_axi_wstrb[0]) carry_reg <= s_axi_wdata[0];
                    default: ;
                endcase
            end
            unique case (state_reg)
                ST_IDLE: begin
                    if (start) begin
                        skip_reg <= 1'b0;
                        jump_reg <= 1'b0;
                        fault_reg <= 1'b0;
                        cnt_reg <= 3'h0;
                        saved_sp_reg <= sp_reg;
                        state_reg <= ST_FINISH;
                        unique case (op)
                            OP_FRAME_SAVE: begin
                                kind_reg <= PK_FRAME;
                                state_reg <= ST_PUSH;
                            end
                            OP_MINUS_IMMEDIATE: ac_reg[acd] <= ac_reg[acd]
                                - {14'h0000, tsel} - 16'h0001;
                            OP_SKIP_GREATER_EQUAL: skip_reg <= alu_bus.ge;
                            OP_SKIP_GREATER: skip_reg <= alu_bus.gt;
                            OP_CPU_FLAG_TEST: skip_reg <= flag_test(tsel, int_en_reg,
                                                                    flags_sync[0]);
                            OP_IO_FLAG_TEST: skip_reg <= flag_test(tsel, flags_sync[2],
                                                                   flags_sync[1]);
                            OP_SKIP_BIT_SET, OP_SKIP_BIT_CLEAR: begin
                                mem_req <= 1'b1;
                                mem_we <= 1'b0;
                                mem_be <= 2'b11;
                                mem_addr <= base + {4'h0, ac_reg[acd][15:4]};
                                state_reg <= ST_WAIT_RD;
                            end
                            OP_WORD_STORE: begin
                                mem_req <= 1'b1;
                                mem_we <= 1'b1;
                                mem_be <= 2'b11;
                                mem_addr <= operand_reg;
                                mem_wdata <= ac_reg[acd];
                                state_reg <= ST_WAIT_WR;
                            end
                            OP_BYTE_STORE: begin
                                mem_req <= 1'b1;
                                mem_we <= 1'b1;
                                mem_be <= ac_reg[acs][0] ? 2'b01 : 2'b10;
                                mem_addr <= {1'b0, ac_reg[acs][15:1]};
                                mem_wdata <= {ac_reg[acd][7:0], ac_reg[acd][7:0]};
                                state_reg <= ST_WAIT_WR;
                            end
                            OP_UNSIGNED_SUB: begin
                                skip_reg <= alu_bus.skip;
                                if (!cmd_reg[FSE_CMD_NOLOAD]) begin
                                    ac_reg[acd] <= alu_bus.result;
                                    carry_reg <= alu_bus.carry_out;
                                end
                            end
                            OP_SYSTEM_CALL: begin
                                map_enable <= 1'b0;
                                kind_reg <= PK_SYSCALL;
                                if (acs == 2'b00 && acd == 2'b00) begin
                                    mem_req <= 1'b1;
                                    mem_we <= 1'b0;
                                    mem_be <= 2'b11;
                                    mem_addr <= FSE_SYSCALL_VEC;
                                    state_reg <= ST_WAIT_RD;
                                end else begin
                                    state_reg <= ST_PUSH;
                                end
                            end
                            default: ;
                        endcase
                    end
                end
                ST_PUSH: begin
                    sp_reg <= sp_reg + 16'h0001;
                    mem_req <= 1'b1;
                    mem_we <= 1'b1;
                    mem_be <= 2'b11;
                    mem_addr <= sp_reg + 16'h0001;
                    mem_wdata <= push_word;
                    state_reg <= ST_WAIT_WR;
                end
                ST_WAIT_WR: begin
                    if (mem_ack) begin
                        mem_req <= 1'b0;
                        mem_we <= 1'b0;
                        cnt_reg <= cnt_reg + 3'h1;
                        if (op != OP_FRAME_SAVE && op != OP_SYSTEM_CALL) begin
                            state_reg <= ST_FINISH;
                        end else if (cnt_reg != FSE_PUSH_LAST) begin
                            state_reg <= ST_PUSH;
                        end else if (kind_reg != PK_FAULT) begin
                            state_reg <= ST_CHECK;
                        end else begin
                            state_reg <= ST_FINISH;
                        end
                    end
                end
                ST_CHECK: begin
                    if (kind_reg == PK_SYSCALL) begin
                        mem_req <= 1'b1;
                        mem_be <= 2'b11;
                        mem_addr <= FSE_SYSCALL_VEC;
                        state_reg <= ST_WAIT_RD;
                    end else if (sp_reg > limit_reg) begin
                        fault_reg <= 1'b1;
                        kind_reg <= PK_FAULT;
                        sp_reg <= saved_sp_reg;
                        cnt_reg <= 3'h0;
                        state_reg <= ST_PUSH;
                    end else begin
                        fp_reg <= sp_reg;
                        ac_reg[3] <= sp_reg;
                        sp_reg <= sp_reg + operand_reg;
                        state_reg <= ST_FINISH;
                    end
                end
                ST_WAIT_RD: begin
                    if (mem_ack) begin
                        mem_req <= 1'b0;
                        state_reg <= ST_FINISH;
                        if (op == OP_SYSTEM_CALL) begin
                            pc_reg <= {1'b0, mem_rdata[14:0]};
                            jump_reg <= 1'b1;
                        end else begin
                            skip_reg <= mem_rdata[4'hF - ac_reg[acd][3:0]]
                                        ^ (op == OP_SKIP_BIT_CLEAR);
                        end
                    end
                end
                ST_FINISH: begin
                    if (!jump_reg) begin
                        pc_reg <= pc_reg + 16'h0001 + {15'h0000, skip_reg};
                    end
                    int_hold <= (op == OP_SYSTEM_CALL);
                    done_pulse <= 1'b1;
                    state_reg <= ST_IDLE;
                end
                default: state_reg <= ST_IDLE;
            endcase
        end
    end
endmodule : fse_core

//--- test/fse_core_assertions.sv
`timescale 1ns/100ps
module fse_core_assertions (
    input logic aclk,
    input logic aresetn,
    input logic s_axi_awvalid,
    input logic s_axi_wvalid,
    input logic s_axi_bvalid,
    input logic s_axi_bready,
    input logic s_axi_arvalid,
    input logic s_axi_arready,
    input logic s_axi_rvalid,
    input logic s_axi_rready,
    input logic mem_req,
    input logic mem_ack,
    input logic [15:0] mem_addr,
    input logic done_pulse
);
    default clocking cb @(posedge aclk); endclocking
    default disable iff (!aresetn);
    sequence mem_wait; mem_req && !mem_ack; endsequence
    a_req_holds: assert property (mem_wait |=> mem_req && $stable(mem_addr))
        else $error("request not held");
    a_req_gap: assert property (mem_ack |=> !mem_req)
        else $error("request without gap");
    a_done_single: assert property (done_pulse |=> !done_pulse) else $error("done too long");
    a_done_idle: assert property (done_pulse |-> !mem_req) else $error("done during access");
    a_write_answer: assert property (s_axi_awvalid && s_axi_wvalid && !s_axi_bvalid
        |=> s_axi_bvalid) else $error("bvalid late");
    a_read_answer: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
        else $error("rvalid late");
    a_bresp_stands: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid)
        else $error("bvalid dropped");
    a_rresp_stands: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid)
        else $error("rvalid dropped");
endmodule : fse_core_assertions
bind fse_core fse_core_assertions u_chk (.*);

//--- test/fse_mem_model.sv
`timescale 1ns/100ps
module fse_mem_model (
    input logic aclk,
    input logic mem_req,
    input logic mem_we,
    input logic [15:0] mem_addr,
    input logic [15:0] mem_wdata,
    input logic [1:0] mem_be,
    input logic [1:0] dly,
    output logic [15:0] mem_rdata,
    output logic mem_ack
);
    logic [15:0] store [logic [15:0]];
    logic [15:0] w;
    logic [1:0] cnt = 2'h0;
    initial {mem_rdata, mem_ack} = 17'h00000;
    always @(posedge aclk) begin
        mem_ack <= 1'b0;
        mem_rdata <= ~mem_rdata;
        w = store.exists(mem_addr) ? store[mem_addr] : '0;
        if (mem_req && !mem_ack && cnt < dly) cnt <= cnt + 2'h1;
        else if (mem_req && !mem_ack) begin
            cnt <= 2'h0;
            mem_ack <= 1'b1;
            mem_rdata <= w;
            if (mem_we && mem_be[1]) w[15:8] = mem_wdata[15:8];
            if (mem_we && mem_be[0]) w[7:0] = mem_wdata[7:0];
            if (mem_we) store[mem_addr] = w;
        end
    end
endmodule : fse_mem_model

//--- test/tb.sv
`timescale 1ns/100ps
module tb;
    import fse_pkg::*;
    typedef struct packed {logic [19:0] cmd; logic [3:0] ctl; logic [15:0] s, d, ac1;
        logic [3:0] inc;} fse_row_t;
    fse_row_t rows [17] = '{76'h00351_0_0000_0002_FFFE_1, 76'h00042_0_FFFF_0001_0001_1,
        76'h00042_0_8000_8000_8000_2, 76'h00043_0_8000_8000_8000_1, 76'h00043_0_0001_FFFF_FFFF_2,
        76'h00044_2_0000_0000_0000_2, 76'h00144_0_0000_0000_0000_2, 76'h00244_0_0000_0000_0000_2,
        76'h00344_0_0000_0000_0000_1, 76'h00045_0_0000_0000_0000_2, 76'h00145_0_0000_0000_0000_1,
        76'h00245_0_0000_0000_0000_1, 76'h00345_0_0000_0000_0000_2, 76'h3044A_0_0003_0005_0002_2,
        76'h3444A_0_0005_0003_0003_1, 76'h00046_0_0000_0000_0000_1, 76'h00047_0_0000_0000_0000_2};
    logic aclk = 0, aresetn = 0, awv = 0, wv = 0, bv, br = 0, arv = 0, rv, rr = 0;
    logic awr, wr_ok, arr, req, we, ack, ih, me, dp, busy = 1, dn = 0, pw = 1;
    logic [7:0] awa = 0, ara = 0;
    logic [31:0] wd = 0, rd;
    logic [1:0] bresp, rresp, be, dly = 0, resp;
    logic [15:0] addr, wdat, mrd, v;
    int num_errors = 0, checks = 0;
    fse_core DUT (.aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awa), .s_axi_awvalid(awv),
        .s_axi_awready(awr), .s_axi_wdata(wd), .s_axi_wstrb(4'hF), .s_axi_wvalid(wv),
        .s_axi_wready(wr_ok), .s_axi_bresp(bresp), .s_axi_bvalid(bv), .s_axi_bready(br),
        .s_axi_araddr(ara), .s_axi_arvalid(arv), .s_axi_arready(arr), .s_axi_rdata(rd),
        .s_axi_rresp(rresp), .s_axi_rvalid(rv), .s_axi_rready(rr), .mem_req(req),
        .mem_we(we), .mem_addr(addr), .mem_wdata(wdat), .mem_be(be), .mem_rdata(mrd),
        .mem_ack(ack), .io_device(), .io_busy(busy), .io_done(dn), .power_flag(pw),
        .map_enable(me), .int_hold(ih), .done_pulse(dp));
    fse_mem_model partner (.aclk(aclk), .mem_req(req), .mem_we(we), .mem_addr(addr),
        .mem_wdata(wdat), .mem_be(be), .dly(dly), .mem_rdata(mrd), .mem_ack(ack));
    initial forever #10 aclk = ~aclk;
    task automatic chk(input logic [15:0] seen, exp, input string what);
        checks++;
        if (seen !== exp) begin
            num_errors++;
            $display("Error %s expected %h seen %h", what, exp, seen);
        end
    endtask : chk
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge aclk);
        awa <= a;
        wd <= d;
        awv <= 1'b1;
        wv <= 1'b1;
        br <= 1'b1;
        do @(posedge aclk); while (!(awr && wr_ok));
        awv <= 1'b0;
        wv <= 1'b0;
        do @(posedge aclk); while (!bv);
        br <= 1'b0;
        resp = bresp;
    endtask : wr
    task automatic rd_reg(input logic [7:0] a);
        @(posedge aclk);
        ara <= a;
        arv <= 1'b1;
        rr <= 1'b1;
        do @(posedge aclk); while (!arr);
        arv <= 1'b0;
        do @(posedge aclk); while (!rv);
        rr <= 1'b0;
        v = rd[15:0];
    endtask : rd_reg
    task automatic run(input logic [19:0] cmd, input logic [3:0] ctl);
        wr(FSE_OFF_CMD, {12'h0, cmd});
        wr(FSE_OFF_CTRL, {28'h0, ctl});
        wr(FSE_OFF_CTRL, {28'h0, ctl | 4'h1});
        while (dp !== 1'b1) @(posedge aclk);
    endtask : run
    task automatic finish_test;
        $display("checks %0d num_errors %0d", checks, num_errors);
        if (num_errors == 0 && checks > 0) $display("NO MISMATCHES");
        else $display("MISMATCHES SEEN");
        $finish;
    endtask : finish_test
    initial begin
        #400000;
        num_errors++;
        finish_test();
    end
    initial begin
        repeat (5) @(posedge aclk);
        aresetn <= 1'b1;
        rd_reg(FSE_OFF_LIMIT);
        chk(v, FSE_RST_LIMIT, "limit");
        foreach (rows[i]) begin
            wr(FSE_OFF_AC0, rows[i].s);
            wr(8'h14, rows[i].d);
            wr(FSE_OFF_PC, 32'h0100);
            run(rows[i].cmd, rows[i].ctl);
            rd_reg(FSE_OFF_PC);
            chk(v, 16'h0100 + rows[i].inc, "pc");
            rd_reg(8'h14);
            chk(v, rows[i].ac1, "ac1");
        end
        wr(8'h40, 32'h1);
        chk({14'h0, resp}, {14'h0, FSE_RESP_SLVERR}, "bresp");
        wr(8'h18, 32'h1234);
        wr(FSE_OFF_OPERAND, 32'h0200);
        run(20'h000A8, 4'h0);
        chk(partner.store[16'h0200], 16'h1234, "stored word");
        dly <= 2'h2;
        wr(FSE_OFF_AC0, 32'h1111);
        wr(8'h1C, 32'h0003);
        wr(FSE_OFF_FP, 32'h0050);
        wr(FSE_OFF_SP, 32'h0100);
        wr(FSE_OFF_CARRY, 32'h1);
        wr(FSE_OFF_OPERAND, 32'h0010);
        run(20'h00000, 4'h0);
        chk(partner.store[16'h0101], 16'h1111, "frame word 1");
        chk(partner.store[16'h0104], 16'h0050, "frame word 4");
        chk(partner.store[16'h0105], 16'h8003, "frame word 5");
        rd_reg(FSE_OFF_FP);
        chk(v, 16'h0105, "fp");
        rd_reg(FSE_OFF_SP);
        chk(v, 16'h0115, "sp");
        partner.store[16'h0002] = 16'h0300;
        run(20'h0005B, 4'h4);
        rd_reg(FSE_OFF_PC);
        chk(v, 16'h0300, "vector pc");
        chk({15'h0, me}, 16'h0000, "map off");
        chk({15'h0, ih}, 16'h0001, "hold set");
        run(20'h0000F, 4'h0);
        chk({15'h0, ih}, 16'h0000, "hold clear");
        finish_test();
    end
endmodule : tb
